// ===== fes_host_model.sv
// Host model that sends mode 0 serial frames
`timescale 1ns/1ns
module fes_host_model (
    // Serial link pins
    output logic      spiClk,
    output logic      chipSelN,
    output logic      serialIn,
    input  wire logic serialOut
);
    logic [7:0] rdByte;
    // Clock rests low and select high between frames
    initial
    begin
        spiClk = 1'b0;
        chipSelN = 1'b1;
        serialIn = 1'b0;
    end
    // MSB first from bit n-1; last eight sampled bits kept
    task automatic frame(input logic [31:0] b, input int n);
        chipSelN = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            #100 serialIn = b[i];
            #62 spiClk = 1'b1;
            rdByte = {rdByte[6:0], serialOut};
            #63 spiClk = 1'b0;
        end
        #100 chipSelN = 1'b1;
        serialIn = ~serialIn; // Released line must not look held
        #100;
    endtask
endmodule

// ===== fes_link_sync.sv
// Pin synchroniser and edge finder for the serial link
`timescale 1ns/1ns

module fes_link_sync (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Raw pins
    input  wire fes_pkg::fes_pins_t pinsRaw,
    // Synchronised levels and edge pulses
    output      fes_pkg::fes_pins_t pinsSync,
    output      fes_pkg::fes_evt_t  evt
);

    fes_pkg::fes_sync_t st_r;
    fes_pkg::fes_sync_t st_nxt;

    // ------------------------------------------------------------------
    // Two stages for metastability, a third only to find edges
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = pinsRaw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    // Chip select idles high so no frame is seen out of reset
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '{s1: 3'b010, s2: 3'b010, s3: 3'b010};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Edges compare the settled stage against its delayed copy
    assign pinsSync      = st_r.s2;
    assign evt.sclkRise  = st_r.s2.sclk & ~st_r.s3.sclk;
    assign evt.sclkFall  = ~st_r.s2.sclk & st_r.s3.sclk;
    assign evt.csRise    = st_r.s2.csN & ~st_r.s3.csN;
    assign evt.csFall    = ~st_r.s2.csN & st_r.s3.csN;

endmodule

// ===== fes_pkg.sv
// Shared constants, opcodes and carrier types of the flash erase/suspend/resume sequencer
package fes_pkg;

    // ------------------------------------------------------------------
    // Instruction opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_READ_STATUS1  = 8'h05;
    localparam logic [7:0] OPC_READ_STATUS2  = 8'h35;
    localparam logic [7:0] OPC_WRITE_STATUS  = 8'h01;
    localparam logic [7:0] OPC_PAGE_PROG     = 8'h02;
    localparam logic [7:0] OPC_QUAD_PROG     = 8'h32;
    localparam logic [7:0] OPC_FAST_PROG     = 8'hf2;
    localparam logic [7:0] OPC_SECREG_PROG   = 8'h42;
    localparam logic [7:0] OPC_SECTOR_ERASE  = 8'h20;
    localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hd8;
    localparam logic [7:0] OPC_CHIP_ERASE_A  = 8'hc7;
    localparam logic [7:0] OPC_CHIP_ERASE_B  = 8'h60;
    localparam logic [7:0] OPC_SECREG_ERASE  = 8'h44;
    localparam logic [7:0] OPC_SUSPEND       = 8'h75;
    localparam logic [7:0] OPC_RESUME        = 8'h7a;

    // ------------------------------------------------------------------
    // Frame lengths in serial bits
    // ------------------------------------------------------------------
    localparam logic [11:0] BITS_OPCODE   = 12'h008;
    localparam logic [11:0] BITS_WRSTATUS = 12'h010;
    localparam logic [11:0] BITS_ADDRESS  = 12'h020;
    localparam logic [11:0] BITS_PROG_MIN = 12'h028;
    localparam logic [11:0] BITS_SAT      = 12'hfff;

    // ------------------------------------------------------------------
    // Status fields and reset values
    // ------------------------------------------------------------------
    localparam int          SR1_WIP_BIT   = 0;
    localparam int          SR1_WEL_BIT   = 1;
    localparam int          SR1_BP_LSB    = 2;
    localparam int          SR2_SUS_BIT   = 7;
    localparam logic [4:0]  BP_RESET      = 5'h00;
    localparam int          BP_BOTTOM_BIT = 3;

    // ------------------------------------------------------------------
    // Self-timed durations in sys_clk cycles (defaults of top parameters)
    // ------------------------------------------------------------------
    localparam int unsigned PROG_CYC_DFLT    = 32'd60000;
    localparam int unsigned SECTOR_CYC_DFLT  = 32'd5000000;
    localparam int unsigned BLOCK32_CYC_DFLT = 32'd15000000;
    localparam int unsigned BLOCK64_CYC_DFLT = 32'd25000000;
    localparam int unsigned CHIP_CYC_DFLT    = 32'd400000000;
    localparam int unsigned WRSR_CYC_DFLT    = 32'd500000;
    localparam int unsigned SECREG_CYC_DFLT  = 32'd5000000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE    = 3'b000,
        OP_PROG    = 3'b001,
        OP_SECTOR  = 3'b010,
        OP_BLOCK32 = 3'b011,
        OP_BLOCK64 = 3'b100,
        OP_CHIP    = 3'b101,
        OP_WRSR    = 3'b110,
        OP_SECREG  = 3'b111
    } fes_op_t;

    typedef struct packed {
        logic sclk;
        logic csN;
        logic si;
    } fes_pins_t;

    typedef struct packed {
        logic sclkRise;
        logic sclkFall;
        logic csRise;
        logic csFall;
    } fes_evt_t;

    typedef struct packed {
        fes_pins_t s1;
        fes_pins_t s2;
        fes_pins_t s3;
    } fes_sync_t;

    typedef struct packed {
        logic [11:0] bitCnt;
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic [7:0]  dataSh;
        logic [7:0]  outSh;
        logic        serOut;
        logic        serOutEn;
        logic [4:0]  bp;
        logic        write_enable_latch;
        logic        write_in_progress;
        logic        suspend_flag;
        fes_op_t     actKind;
        logic [23:0] actAddr;
        logic [31:0] actCnt;
        fes_op_t     susKind;
        logic [23:0] susAddr;
        logic [31:0] susCnt;
        logic        opStart;
        logic        opDone;
        logic [7:0]  progByte;
        logic        progByteValid;
    } fes_core_t;

endpackage

// ===== fes_sequencer.sv
// Command sequencer for erase, chip erase, suspend and resume of a serial NOR flash
`timescale 1ns/1ns

// Overview of operation
// [R1] Block erase: D8h plus three address bytes
// [R2] Host must set write enable before erasing
// [R3] Block erase needs exact 32-bit frame
// [R4] Chip select rise starts timed erase, busy
// [R5] Status reads answered while erase runs
// [R6] Write enable cleared before erase ends
// [R7] Protected block erase is dropped
// [R8] Chip erase C7h/60h erases whole array
// [R9] Chip erase needs exact 8-bit frame
// [R10] Chip erase timed, clears busy, write enable
// [R11] Chip erase only with zero protect bits
// [R12] Suspend 75h halts erase or program
// [R13] Erase suspend refuses status write, erases
// [R14] Suspend ignored during chip erase
// [R15] Program suspend refuses status write, programs
// [R16] Status write cannot be suspended
// [R17] Reads of suspended page run, data unreliable
// [R18] Program suspend drops erase covering page
// [R19] Erase suspend reads outside region valid
// [R20] Erase suspend drops program in region
// [R21] Host avoids programs in suspended region
// [R22] Resume 7Ah only when suspended, idle
// [R23] Resume clears suspend, sets busy quickly
// [R24] Suspend sets flag, clears busy
module fes_sequencer #(
    parameter int unsigned PROG_CYCLES    = fes_pkg::PROG_CYC_DFLT,
    parameter int unsigned SECTOR_CYCLES  = fes_pkg::SECTOR_CYC_DFLT,
    parameter int unsigned BLOCK32_CYCLES = fes_pkg::BLOCK32_CYC_DFLT,
    parameter int unsigned BLOCK64_CYCLES = fes_pkg::BLOCK64_CYC_DFLT,
    parameter int unsigned CHIP_CYCLES    = fes_pkg::CHIP_CYC_DFLT,
    parameter int unsigned WRSR_CYCLES    = fes_pkg::WRSR_CYC_DFLT,
    parameter int unsigned SECREG_CYCLES  = fes_pkg::SECREG_CYC_DFLT
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Serial link pins
    input  wire logic        spiClk,
    input  wire logic        chipSelN,
    input  wire logic        serialIn,
    output      logic        serialOut,
    output      logic        serialOutEn,
    // Status flags
    output      logic        writeInProgress,
    output      logic        writeEnableLatch,
    output      logic        suspendFlag,
    output      logic [4:0]  blockProtectBits,
    // Array operation control
    output      logic        opStart,
    output      logic        opDone,
    output      logic [2:0]  opKind,
    output      logic [23:0] opAddr,
    output      logic [7:0]  progByte,
    output      logic        progByteValid
);

    fes_pkg::fes_core_t s_r;
    fes_pkg::fes_core_t s_nxt;
    fes_pkg::fes_pins_t pinsRaw;
    fes_pkg::fes_pins_t pins;
    fes_pkg::fes_evt_t  evt;

    // ------------------------------------------------------------------
    // Link front end
    // ------------------------------------------------------------------
    assign pinsRaw = '{sclk: spiClk, csN: chipSelN, si: serialIn};

    fes_link_sync u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pinsRaw  (pinsRaw),
        .pinsSync (pins),
        .evt      (evt)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Duration of each self-timed operation
    function automatic logic [31:0] opCycles(input fes_pkg::fes_op_t k);
        case (k)
            fes_pkg::OP_PROG:    opCycles = PROG_CYCLES;
            fes_pkg::OP_SECTOR:  opCycles = SECTOR_CYCLES;
            fes_pkg::OP_BLOCK32: opCycles = BLOCK32_CYCLES;
            fes_pkg::OP_BLOCK64: opCycles = BLOCK64_CYCLES;
            fes_pkg::OP_CHIP:    opCycles = CHIP_CYCLES;
            fes_pkg::OP_WRSR:    opCycles = WRSR_CYCLES;
            fes_pkg::OP_SECREG:  opCycles = SECREG_CYCLES;
            default:             opCycles = 32'h00000001;
        endcase
    endfunction

    // True when two addresses fall in the same unit that an operation covers
    function automatic logic sameUnit(input fes_pkg::fes_op_t k,
                                      input logic [23:0] a,
                                      input logic [23:0] b);
        case (k)
            fes_pkg::OP_PROG:    sameUnit = (a[23:8] == b[23:8]);
            fes_pkg::OP_SECTOR:  sameUnit = (a[23:12] == b[23:12]);
            fes_pkg::OP_BLOCK32: sameUnit = (a[23:15] == b[23:15]);
            fes_pkg::OP_BLOCK64: sameUnit = (a[23:16] == b[23:16]);
            default:             sameUnit = 1'b1;
        endcase
    endfunction

    // Protected range: low bits give 2^(n-1) blocks of 64KB, n>=5 all
    function automatic logic isProtected(input logic [4:0] bp, input logic [23:0] a);
        logic [4:0] span;
        logic [3:0] blk;
        span = 5'h00;
        blk  = a[19:16];
        if (bp[2:0] >= 3'h5)
        begin
            span = 5'h10;
        end
        else if (bp[2:0] != 3'h0)
        begin
            span = 5'(5'h01 << (bp[2:0] - 3'h1));
        end
        if (bp[fes_pkg::BP_BOTTOM_BIT])
        begin
            isProtected = ({1'b0, blk} < span);
        end
        else
        begin
            isProtected = ({1'b0, blk} >= (5'h10 - span));
        end
    endfunction

    function automatic logic isProgOpc(input logic [7:0] o);
        isProgOpc = (o == fes_pkg::OPC_PAGE_PROG) || (o == fes_pkg::OPC_QUAD_PROG) ||
                    (o == fes_pkg::OPC_FAST_PROG) || (o == fes_pkg::OPC_SECREG_PROG);
    endfunction

    function automatic logic isEraseKind(input fes_pkg::fes_op_t k);
        isEraseKind = (k == fes_pkg::OP_SECTOR) || (k == fes_pkg::OP_BLOCK32) ||
                      (k == fes_pkg::OP_BLOCK64) || (k == fes_pkg::OP_SECREG) ||
                      (k == fes_pkg::OP_CHIP);
    endfunction

    // Status byte shifted out for a status read
    function automatic logic [7:0] statusByte(input logic [7:0] o, input fes_pkg::fes_core_t c);
        logic [7:0] b;
        b = 8'h00;
        if (o == fes_pkg::OPC_READ_STATUS1)
        begin
            b[fes_pkg::SR1_WIP_BIT] = c.write_in_progress;
            b[fes_pkg::SR1_WEL_BIT] = c.write_enable_latch;
            b[fes_pkg::SR1_BP_LSB +: 5] = c.bp;
        end
        else
        begin
            b[fes_pkg::SR2_SUS_BIT] = c.suspend_flag;
        end
        statusByte = b;
    endfunction

    // Launch a self-timed operation; write enable drops at once
    function automatic fes_pkg::fes_core_t startOp(input fes_pkg::fes_core_t c,
                                                   input fes_pkg::fes_op_t k,
                                                   input logic [23:0] a);
        fes_pkg::fes_core_t r;
        r         = c;
        r.actKind = k;
        r.actAddr = a;
        r.actCnt  = opCycles(k);
        r.write_in_progress     = 1'b1;
        r.write_enable_latch     = 1'b0;
        r.opStart = 1'b1;
        startOp   = r;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic       frameOpc;
    logic       frameAddr;
    logic       frameProg;
    logic       eraseSusp;
    logic       progSusp;
    logic [7:0] opc;
    logic [7:0] stByte;

    always_comb
    begin
        s_nxt               = s_r;
        s_nxt.opStart       = 1'b0;
        s_nxt.opDone        = 1'b0;
        s_nxt.progByteValid = 1'b0;
        opc       = s_r.opcode;
        stByte    = 8'h00;
        frameOpc  = (s_r.bitCnt == fes_pkg::BITS_OPCODE);
        frameAddr = (s_r.bitCnt == fes_pkg::BITS_ADDRESS);
        frameProg = (s_r.bitCnt >= fes_pkg::BITS_PROG_MIN) && (s_r.bitCnt[2:0] == 3'h0);
        eraseSusp = s_r.suspend_flag && isEraseKind(s_r.susKind);
        progSusp  = s_r.suspend_flag && (s_r.susKind == fes_pkg::OP_PROG);

        // Self-timed operation countdown
        if (s_r.actKind != fes_pkg::OP_NONE)
        begin
            if (s_r.actCnt <= 32'h00000001)
            begin
                s_nxt.actKind = fes_pkg::OP_NONE;
                s_nxt.write_in_progress     = 1'b0;                          // see [R4]
                s_nxt.write_enable_latch     = 1'b0;                          // see [R10]
                s_nxt.opDone  = 1'b1;
            end
            else
            begin
                s_nxt.actCnt = s_r.actCnt - 32'h00000001;
            end
        end

        // New frame: forget the previous one
        if (evt.csFall)
        begin
            s_nxt.bitCnt   = 12'h000;
            s_nxt.serOutEn = 1'b0;
        end

        // Sample serial input on clock rise inside a frame
        if (evt.sclkRise && !pins.csN)
        begin
            if (s_r.bitCnt < fes_pkg::BITS_OPCODE)
            begin
                s_nxt.opcode = {s_r.opcode[6:0], pins.si};
            end
            else if (s_r.bitCnt < fes_pkg::BITS_ADDRESS && opc != fes_pkg::OPC_WRITE_STATUS)
            begin
                s_nxt.addr = {s_r.addr[22:0], pins.si};        // see [R1]
            end
            else
            begin
                s_nxt.dataSh = {s_r.dataSh[6:0], pins.si};
                if (s_r.bitCnt[2:0] == 3'h7 && isProgOpc(opc))
                begin
                    s_nxt.progByte      = {s_r.dataSh[6:0], pins.si};
                    s_nxt.progByteValid = 1'b1;
                end
            end
            if (s_r.bitCnt != fes_pkg::BITS_SAT)
            begin
                s_nxt.bitCnt = s_r.bitCnt + 12'h001;
            end
        end

        // Status reads are served at any time, busy or not
        if (evt.sclkFall && !pins.csN && s_r.bitCnt >= fes_pkg::BITS_OPCODE &&
            (opc == fes_pkg::OPC_READ_STATUS1 || opc == fes_pkg::OPC_READ_STATUS2))
        begin
            s_nxt.serOutEn = 1'b1;                             // see [R5]
            if (s_r.bitCnt[2:0] == 3'h0)
            begin
                stByte       = statusByte(opc, s_nxt);
                s_nxt.serOut = stByte[7];
                s_nxt.outSh  = {stByte[6:0], 1'b0};
            end
            else
            begin
                s_nxt.serOut = s_r.outSh[7];
                s_nxt.outSh  = {s_r.outSh[6:0], 1'b0};
            end
        end

        // End of frame: decide on the command; reads anywhere never block
        if (evt.csRise)
        begin
            s_nxt.serOutEn = 1'b0;                             // see [R17] see [R19]
            if (opc == fes_pkg::OPC_SUSPEND && frameOpc)
            begin
                // Only programs (any program opcode) and sector/block erase can pause
                if (s_nxt.write_in_progress && !s_r.suspend_flag &&
                    (s_nxt.actKind == fes_pkg::OP_PROG || s_nxt.actKind == fes_pkg::OP_SECTOR ||
                     s_nxt.actKind == fes_pkg::OP_BLOCK32 ||
                     s_nxt.actKind == fes_pkg::OP_BLOCK64))    // see [R12] see [R14] see [R16]
                begin
                    s_nxt.susKind = s_nxt.actKind;
                    s_nxt.susAddr = s_nxt.actAddr;
                    s_nxt.susCnt  = s_nxt.actCnt;
                    s_nxt.actKind = fes_pkg::OP_NONE;
                    s_nxt.suspend_flag     = 1'b1;                      // see [R24]
                    s_nxt.write_in_progress     = 1'b0;
                end
            end
            else if (opc == fes_pkg::OPC_RESUME && frameOpc)
            begin
                if (s_r.suspend_flag && !s_nxt.write_in_progress)                     // see [R22]
                begin
                    s_nxt.actKind = s_r.susKind;
                    s_nxt.actAddr = s_r.susAddr;
                    s_nxt.actCnt  = s_r.susCnt;
                    s_nxt.susKind = fes_pkg::OP_NONE;
                    s_nxt.suspend_flag     = 1'b0;                      // see [R23]
                    s_nxt.write_in_progress     = 1'b1;
                end
            end
            else if (!s_nxt.write_in_progress)
            begin
                if (opc == fes_pkg::OPC_WRITE_ENABLE && frameOpc)
                begin
                    s_nxt.write_enable_latch = 1'b1;
                end
                else if (opc == fes_pkg::OPC_WRITE_DISABLE && frameOpc)
                begin
                    s_nxt.write_enable_latch = 1'b0;
                end
                else if (s_r.write_enable_latch)                              // see [R2]
                begin
                    if ((opc == fes_pkg::OPC_BLOCK64_ERASE || opc == fes_pkg::OPC_BLOCK32_ERASE ||
                         opc == fes_pkg::OPC_SECTOR_ERASE) && frameAddr)  // see [R3]
                    begin
                        if (!eraseSusp && !isProtected(s_r.bp, s_r.addr) &&
                            !(progSusp && sameUnit(opc == fes_pkg::OPC_SECTOR_ERASE ?
                                  fes_pkg::OP_SECTOR : (opc == fes_pkg::OPC_BLOCK32_ERASE ?
                                  fes_pkg::OP_BLOCK32 : fes_pkg::OP_BLOCK64),
                                  s_r.addr, s_r.susAddr)))  // see [R7] see [R13] see [R18]
                        begin
                            s_nxt = startOp(s_nxt,
                                opc == fes_pkg::OPC_SECTOR_ERASE ? fes_pkg::OP_SECTOR :
                                (opc == fes_pkg::OPC_BLOCK32_ERASE ? fes_pkg::OP_BLOCK32 :
                                 fes_pkg::OP_BLOCK64), s_r.addr);  // see [R4] see [R6]
                        end
                    end
                    else if (opc == fes_pkg::OPC_SECREG_ERASE && frameAddr)
                    begin
                        if (!eraseSusp)                        // see [R13]
                        begin
                            s_nxt = startOp(s_nxt, fes_pkg::OP_SECREG, s_r.addr);
                        end
                    end
                    else if ((opc == fes_pkg::OPC_CHIP_ERASE_A ||
                              opc == fes_pkg::OPC_CHIP_ERASE_B) && frameOpc)  // see [R9]
                    begin
                        // Whole array covers any paused page too
                        if (!s_r.suspend_flag && s_r.bp == 5'h00)        // see [R11] see [R13] see [R18]
                        begin
                            s_nxt = startOp(s_nxt, fes_pkg::OP_CHIP, 24'h000000);  // see [R8]
                        end
                    end
                    else if (opc == fes_pkg::OPC_WRITE_STATUS &&
                             s_r.bitCnt == fes_pkg::BITS_WRSTATUS)
                    begin
                        if (!s_r.suspend_flag)                          // see [R13] see [R15]
                        begin
                            s_nxt    = startOp(s_nxt, fes_pkg::OP_WRSR, 24'h000000);
                            s_nxt.bp = s_r.dataSh[fes_pkg::SR1_BP_LSB +: 5];
                        end
                    end
                    else if (isProgOpc(opc) && frameProg)
                    begin
                        // A program outside the unit of the paused erase still runs
                        if (!progSusp && !isProtected(s_r.bp, s_r.addr) &&
                            !(eraseSusp && sameUnit(s_r.susKind, s_r.addr, s_r.susAddr)))
                        begin                                  // see [R15] see [R20] see [R21]
                            s_nxt = startOp(s_nxt, fes_pkg::OP_PROG, s_r.addr);
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r         <= '0;
            s_r.bp      <= fes_pkg::BP_RESET;
            s_r.actKind <= fes_pkg::OP_NONE;
            s_r.susKind <= fes_pkg::OP_NONE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all taken from the state register
    // ------------------------------------------------------------------
    assign serialOut        = s_r.serOut;
    assign serialOutEn      = s_r.serOutEn;
    assign writeInProgress  = s_r.write_in_progress;
    assign writeEnableLatch = s_r.write_enable_latch;
    assign suspendFlag      = s_r.suspend_flag;
    assign blockProtectBits = s_r.bp;
    assign opStart          = s_r.opStart;
    assign opDone           = s_r.opDone;
    assign opKind           = s_r.actKind;
    assign opAddr           = s_r.actAddr;
    assign progByte         = s_r.progByte;
    assign progByteValid    = s_r.progByteValid;

endmodule

// ===== fes_sequencer_bench.sv
// Self-checking bench of the erase/suspend/resume sequencer
`timescale 1ns/1ns
module fes_sequencer_bench;
    logic        sys_clk, rst, spiClk, chipSelN, serialIn, serialOut, serialOutEn;
    logic        busy, latch, paused, opStart, opDone;
    logic [4:0]  blockProtectBits;
    logic [2:0]  kind;
    logic [23:0] opAddr;
    int          n_errors = 0, samples_checked = 0, cyc = 0;
    // Erase count outlasts several frames so suspend lands mid-erase
    fes_sequencer #(.BLOCK64_CYCLES(2000), .CHIP_CYCLES(500), .WRSR_CYCLES(60)) dut (
        .sys_clk, .rst, .spiClk, .chipSelN, .serialIn, .serialOut, .serialOutEn,
        .writeInProgress(busy), .writeEnableLatch(latch), .suspendFlag(paused),
        .blockProtectBits, .opStart, .opDone, .opKind(kind), .opAddr, .progByte(),
        .progByteValid());
    fes_host_model host (.spiClk, .chipSelN, .serialIn, .serialOut);
    task automatic chk(input string nm, input logic [23:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            n_errors++;
        end
    endtask
    task automatic results();
        if (n_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic f(input logic [31:0] b, input int n);
        host.frame(b, n);
    endtask
    // Bounded wait for the self-timed cycle to end
    task automatic idle();
        for (int i = 0; i < 3000 && busy !== 1'b0; i++)
            @(posedge sys_clk);
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Hang guard, well above the expected run
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            results();
        end
    end
    initial
    begin
        rst = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1 rst = 1'b0;
        f(32'h06, 8);
        f(32'hd8012345, 32);
        chk("kind", {kind, latch}, 24'h8);
        chk("addr", opAddr, 24'h012345);
        f(32'h0500, 16);
        chk("status", host.rdByte, 24'h01);
        chk("drive off", serialOutEn, 24'h0);
        f(32'h75, 8);
        chk("pause", {paused, busy}, 24'h2);
        f(32'h3500, 16);
        chk("pause read", host.rdByte, 24'h80);
        f(32'h06, 8);
        f(32'hc7, 8);
        chk("erase in pause", kind, 24'h0);
        f(32'h7a, 8);
        chk("resume", {paused, busy}, 24'h1);
        idle();
        chk("end", {latch, busy}, 24'h0);
        f(32'h7a, 8);
        chk("idle resume", busy, 24'h0);
        f(32'hd8000000, 32);
        chk("no latch", busy, 24'h0);
        f(32'h06, 8);
        f(32'h6c000000, 31);
        chk("short frame", busy, 24'h0);
        f(32'h0c0, 9);
        chk("long chip", busy, 24'h0);
        f(32'hc7, 8);
        chk("chip", {kind, busy}, 24'hb);
        f(32'h75, 8);
        chk("chip pause", {paused, busy}, 24'h1);
        idle();
        chk("chip end", {latch, busy}, 24'h0);
        f(32'h06, 8);
        f(32'h0104, 16);
        idle();
        chk("protect", blockProtectBits, 24'h01);
        f(32'h06, 8);
        f(32'hd8ff0000, 32);
        chk("top block", busy, 24'h0);
        f(32'h60, 8);
        chk("chip guarded", busy, 24'h0);
        results();
    end
endmodule

// ===== fes_sequencer_chk.sv
// Port checker for the erase/suspend/resume sequencer
`timescale 1ns/1ns
module fes_sequencer_chk (
    // Clock, reset and flags
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       writeInProgress,
    input wire logic       writeEnableLatch,
    input wire logic       suspendFlag,
    input wire logic [4:0] blockProtectBits,
    input wire logic       opStart,
    input wire logic       opDone,
    input wire logic [2:0] opKind
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Resume is a fall of the flag; start pulses with the flag set the cycle before are left out
    sequence sResume; $fell(suspendFlag); endsequence
    sequence sFresh; opStart && opKind != 3'h0 && !$past(suspendFlag); endsequence
    a_start_busy: assert property (sFresh |-> writeInProgress)
        else $error("start without busy");
    a_start_latch: assert property (sFresh |-> !writeEnableLatch)
        else $error("latch kept at start");
    a_done_idle: assert property (opDone |-> !writeInProgress && opKind == 3'h0)
        else $error("busy after done");
    a_done_latch: assert property (opDone |-> !writeEnableLatch)
        else $error("latch after done");
    a_chip_free: assert property (opStart && opKind == 3'h5 |-> blockProtectBits == 5'h00)
        else $error("chip erase protected");
    a_chip_nosus: assert property (opKind == 3'h5 |-> !suspendFlag)
        else $error("chip erase paused");
    a_sus_halt: assert property ($rose(suspendFlag) |-> !writeInProgress && opKind == 3'h0)
        else $error("pause kept busy");
    a_resume_busy: assert property (sResume |-> writeInProgress)
        else $error("resume not busy");
endmodule
bind fes_sequencer fes_sequencer_chk chk (.sys_clk, .rst, .writeInProgress,
    .writeEnableLatch, .suspendFlag, .blockProtectBits, .opStart, .opDone, .opKind);
